// file: design/swl_pkg.sv
/*
 * Shared constants for the single-wire slave link: timing fractions, opcodes, frame layout.
 * Assumes a 50 MHz system clock; all times are converted to cycles with these constants.
 */
package swl_pkg;
	localparam int CLK_HZ = 50_000_000;
	// Nominal host bit period at multiplier 1, in nanoseconds (173.6 us).
	localparam int BIT_PERIOD_NS = 173_600;
	localparam int BIT_PERIOD_CYC = (BIT_PERIOD_NS / 20);
	// Thresholds in thousandths of a bit period.
	localparam int GLITCH_MIL = 124;
	localparam int ONE_MIN_MIL = 227;
	localparam int ONE_MAX_MIL = 453;
	localparam int ZERO_MIN_MIL = 591;
	localparam int ZERO_MAX_MIL = 824;
	localparam int BRK_MIN_MIL = 1000;
	localparam int BRK_MAX_MIL = 100_000;
	localparam int TX_ONE_MIL = 304;
	localparam int TX_ZERO_MIL = 696;
	localparam int TX_BRK_MIL = 1391;
	// Inactivity timeout before auto sleep, in bit periods.
	localparam int IDLE_BITS = 64;
	localparam int CNT_W = 24;
	localparam int INSTR_BITS = 16;
	// Instruction fields, bit 0 received first.
	localparam int F_CS = 0;
	localparam int F_OP = 1;
	localparam int F_BANK = 3;
	localparam int F_ADDR = 5;
	localparam int F_BYTES = 13;
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_READ_CRC = 2'h2;
	localparam logic [1:0] OP_SLEEP = 2'h3;
	localparam logic [1:0] BANK_CTRL = 2'h1;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] CRC_POLY_REV = 8'h8C;
	typedef enum logic [1:0] {SWL_SYM_ONE, SWL_SYM_ZERO, SWL_SYM_BRK} swl_sym_e;
endpackage : swl_pkg

// file: design/swl_slave.sv
/*
 * Slave end of a single-wire pulse-width-coded link: decodes host symbols, runs
 * write/read/read-with-CRC/sleep instructions and answers reads with its own symbols.
 * Assumes a pull-up on the line and an external register file on the user ports.
 */
`timescale 1ns/1ps
module swl_slave #(
	parameter int CNT_W = swl_pkg::CNT_W,
	parameter int BIT_CYC_BASE = swl_pkg::BIT_PERIOD_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_line,
	output logic o_line,
	output logic o_line_oe_n,
	input wire logic [1:0] i_rate_sel,
	input wire logic i_chip_addr,
	input wire logic i_error_irq_enable,
	input wire logic i_auto_sleep_en,
	input wire logic i_rom_busy,
	input wire logic i_auth_order_err,
	input wire logic i_ready_req,
	output logic o_asleep,
	output logic o_rom_busy_flag,
	output logic o_line_error_flag,
	output logic [15:0] o_instr,
	output logic o_instr_valid,
	output logic [7:0] o_wr_data,
	output logic o_wr_valid,
	output logic o_rd_req,
	input wire logic [7:0] i_rd_data
);
	typedef enum logic [2:0] {SWL_INSTR, SWL_WDATA, SWL_IGNORE, SWL_RD_GAP, SWL_RD_TX,
		SWL_SLEEP} swl_state_e;

	function automatic logic [CNT_W-1:0] frac(input logic [CNT_W-1:0] bc, input int mil);
		logic [CNT_W+11:0] p;
		p = ({12'h000, bc} * 36'(mil)) / 36'd1000;
		return p[CNT_W-1:0];
	endfunction : frac

	function automatic logic [4:0] byte_count(input logic [2:0] f);
		return (f == 3'h7) ? 5'h10 : {2'h0, f};
	endfunction : byte_count

	swl_state_e st_reg, st_next;
	logic line_d_reg;
	logic [CNT_W-1:0] low_cnt_reg;
	logic [CNT_W-1:0] idle_cnt_reg;
	logic [15:0] sh_reg;
	logic [4:0] bit_cnt_reg;
	logic [4:0] bytes_left_reg;
	logic [7:0] tx_byte_reg;
	logic [3:0] tx_bit_reg;
	logic [7:0] crc_reg;
	logic crc_on_reg;
	logic crc_sent_reg;
	logic busy_flag_reg;
	logic err_flag_reg;
	logic [15:0] instr_reg;
	logic instr_valid_reg;
	logic [7:0] wr_data_reg;
	logic wr_valid_reg;
	logic rd_req_reg;
	logic brk_pend_reg;

	// Bit period scaled by the rate setting; code 1 is the base period.
	logic [CNT_W-1:0] bit_cyc;
	assign bit_cyc = (i_rate_sel == 2'h0) ? CNT_W'(BIT_CYC_BASE * 2) :
		(i_rate_sel == 2'h1) ? CNT_W'(BIT_CYC_BASE) :
		(i_rate_sel == 2'h2) ? CNT_W'(BIT_CYC_BASE / 2) :
		CNT_W'(BIT_CYC_BASE / 4);

	logic rise;
	logic fall;
	logic [CNT_W-1:0] pw;
	logic is_glitch;
	logic is_one;
	logic is_zero;
	logic is_brk;
	logic bad_pw;
	logic rx_bit;
	logic tx_pull;
	logic tx_busy;
	logic tx_start;
	swl_pkg::swl_sym_e tx_sym;
	logic own_tx;
	assign own_tx = tx_busy;
	// Our own pulses are ignored by the receiver so a transmitted symbol is not echoed back.
	assign fall = line_d_reg && !i_line && !own_tx;
	assign rise = !line_d_reg && i_line && !own_tx;
	assign pw = low_cnt_reg;
	assign is_glitch = pw < frac(bit_cyc, swl_pkg::GLITCH_MIL);
	assign is_one = pw >= frac(bit_cyc, swl_pkg::ONE_MIN_MIL) &&
		pw <= frac(bit_cyc, swl_pkg::ONE_MAX_MIL);
	assign is_zero = pw >= frac(bit_cyc, swl_pkg::ZERO_MIN_MIL) &&
		pw <= frac(bit_cyc, swl_pkg::ZERO_MAX_MIL);
	assign is_brk = pw >= frac(bit_cyc, swl_pkg::BRK_MIN_MIL) &&
		{12'h000, pw} <= ({12'h000, bit_cyc} * 36'd100);
	assign bad_pw = rise && !is_one && !is_zero && !is_brk;
	assign rx_bit = is_one;

	logic sym_rx;
	logic brk_rx;
	assign sym_rx = rise && (is_one || is_zero) && st_reg != SWL_SLEEP;
	assign brk_rx = rise && is_brk;

	logic [15:0] instr_full;
	assign instr_full = {rx_bit, sh_reg[15:1]};
	logic instr_done;
	assign instr_done = sym_rx && st_reg == SWL_INSTR && bit_cnt_reg == 5'd15;
	// Sleep is taken as soon as the opcode is complete, so later pulses are not frame bits.
	logic sleep_cmd;
	assign sleep_cmd = sym_rx && st_reg == SWL_INSTR && bit_cnt_reg == 5'd2 &&
		instr_full[15:14] == swl_pkg::OP_SLEEP && instr_full[13] == i_chip_addr;
	logic cs_ok;
	assign cs_ok = instr_full[swl_pkg::F_CS] == i_chip_addr;
	logic [1:0] op;
	assign op = instr_full[swl_pkg::F_OP +: 2];
	logic [4:0] nbytes;
	assign nbytes = byte_count(instr_full[swl_pkg::F_BYTES +: 3]);
	logic bad_instr;
	assign bad_instr = op != swl_pkg::OP_SLEEP &&
		(nbytes == 5'd0 || nbytes == 5'd3 || nbytes == 5'd5 || nbytes == 5'd6);
	logic is_stat_rd;
	assign is_stat_rd = (op == swl_pkg::OP_READ || op == swl_pkg::OP_READ_CRC) &&
		instr_full[swl_pkg::F_BANK +: 2] == swl_pkg::BANK_CTRL &&
		instr_full[swl_pkg::F_ADDR +: 8] == swl_pkg::ADDR_STATUS;
	logic idle_to;
	assign idle_to = {12'h000, idle_cnt_reg} >= ({12'h000, bit_cyc} * 36'(swl_pkg::IDLE_BITS));
	logic flag_irq;
	assign flag_irq = busy_flag_reg || (err_flag_reg && i_error_irq_enable);
	// An access other than a status read during a rom write interrupts at once, before its flag is visible.
	logic irq_now;
	assign irq_now = flag_irq || i_rom_busy;

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			SWL_INSTR: begin
				if (sleep_cmd) begin
					st_next = SWL_SLEEP;
				end else if (instr_done) begin
					if (!cs_ok || i_rom_busy || bad_instr) begin
						st_next = SWL_IGNORE;
					end else if (op == swl_pkg::OP_SLEEP) begin
						st_next = SWL_SLEEP;
					end else if (op == swl_pkg::OP_WRITE) begin
						st_next = SWL_WDATA;
					end else begin
						st_next = SWL_RD_GAP;
					end
				end
			end
			SWL_WDATA: begin
				if (sym_rx && bit_cnt_reg == 5'd7 && bytes_left_reg == 5'd1) begin
					st_next = SWL_INSTR;
				end
			end
			SWL_IGNORE: st_next = SWL_IGNORE;
			SWL_RD_GAP: begin
				if (!tx_busy) begin
					st_next = SWL_RD_TX;
				end
			end
			SWL_RD_TX: begin
				if (!tx_busy && !tx_start && tx_bit_reg == 4'd8 && bytes_left_reg == 5'd0 &&
					(!crc_on_reg || crc_sent_reg)) begin
					st_next = SWL_INSTR;
				end
			end
			SWL_SLEEP: st_next = SWL_SLEEP;
		endcase
		if (brk_rx) begin
			st_next = SWL_INSTR;
		end else if (i_auto_sleep_en && idle_to && i_line && st_reg != SWL_RD_TX) begin
			st_next = SWL_SLEEP;
		end
	end

	// Transmit requests: data bits during reads, breaks for readiness and interrupts.
	logic tx_data;
	assign tx_data = st_reg == SWL_RD_TX && !tx_busy && tx_bit_reg != 4'd8;
	assign tx_start = tx_data || (brk_pend_reg && !tx_busy && i_line &&
		(st_reg == SWL_INSTR || st_reg == SWL_IGNORE));
	assign tx_sym = !tx_data ? swl_pkg::SWL_SYM_BRK :
		tx_byte_reg[0] ? swl_pkg::SWL_SYM_ONE : swl_pkg::SWL_SYM_ZERO;
	logic crc_fb;
	assign crc_fb = crc_reg[0] ^ tx_byte_reg[0];
	logic load_byte;
	assign load_byte = st_reg == SWL_RD_TX && !tx_busy && !tx_start && tx_bit_reg == 4'd8 &&
		st_next == SWL_RD_TX;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			st_reg <= SWL_INSTR;
			line_d_reg <= 1'b1;
			low_cnt_reg <= '0;
			idle_cnt_reg <= '0;
			sh_reg <= 16'h0000;
			bit_cnt_reg <= 5'h00;
			bytes_left_reg <= 5'h00;
			tx_byte_reg <= 8'h00;
			tx_bit_reg <= 4'h8;
			crc_reg <= 8'h00;
			crc_on_reg <= 1'b0;
			crc_sent_reg <= 1'b0;
			busy_flag_reg <= 1'b0;
			err_flag_reg <= 1'b0;
			instr_reg <= 16'h0000;
			instr_valid_reg <= 1'b0;
			wr_data_reg <= 8'h00;
			wr_valid_reg <= 1'b0;
			rd_req_reg <= 1'b0;
			brk_pend_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			line_d_reg <= i_line;
			instr_valid_reg <= 1'b0;
			wr_valid_reg <= 1'b0;
			rd_req_reg <= 1'b0;
			low_cnt_reg <= (!i_line && !own_tx) ? low_cnt_reg + 1'b1 : '0;
			idle_cnt_reg <= (fall || !i_line || tx_busy || brk_rx) ? '0 : idle_cnt_reg + 1'b1;
			if (brk_rx || (sym_rx && st_reg != SWL_INSTR && st_reg != SWL_WDATA)) begin
				bit_cnt_reg <= 5'h00;
			end else if (sym_rx) begin
				sh_reg <= instr_full;
				bit_cnt_reg <= (st_reg == SWL_WDATA && bit_cnt_reg == 5'd7) ? 5'h00 :
					(instr_done ? 5'h00 : bit_cnt_reg + 1'b1);
			end
			if (instr_done && cs_ok) begin
				instr_reg <= instr_full;
				instr_valid_reg <= !i_rom_busy && !bad_instr;
				bytes_left_reg <= nbytes;
				crc_on_reg <= op == swl_pkg::OP_READ_CRC;
				crc_sent_reg <= 1'b0;
				crc_reg <= 8'h00;
			end
			if (sym_rx && st_reg == SWL_WDATA && bit_cnt_reg == 5'd7) begin
				wr_data_reg <= instr_full[15:8];
				wr_valid_reg <= 1'b1;
				bytes_left_reg <= bytes_left_reg - 1'b1;
			end
			if (load_byte) begin
				if (bytes_left_reg != 5'd0) begin
					tx_byte_reg <= i_rd_data;
					rd_req_reg <= 1'b1;
					bytes_left_reg <= bytes_left_reg - 1'b1;
				end else begin
					tx_byte_reg <= crc_reg;
					crc_sent_reg <= 1'b1;
				end
				tx_bit_reg <= 4'h0;
			end else if (tx_data) begin
				tx_byte_reg <= {1'b0, tx_byte_reg[7:1]};
				tx_bit_reg <= tx_bit_reg + 1'b1;
				if (bytes_left_reg != 5'd0 || !crc_sent_reg) begin
					crc_reg <= {crc_fb, crc_reg[7:1]} ^ (crc_fb ? {1'b0, swl_pkg::CRC_POLY_REV[6:0]}
						: 8'h00);
				end
			end
			// A new interrupt request wins over the clear of a break that is just starting.
			if (instr_done && cs_ok && irq_now && !is_stat_rd) begin
				brk_pend_reg <= 1'b1;
			end else if (tx_start && !tx_data) begin
				brk_pend_reg <= 1'b0;
			end else if ((st_reg == SWL_SLEEP && brk_rx) || i_ready_req) begin
				brk_pend_reg <= 1'b1;
			end
			// Set wins over the status-read clear.
			if (instr_done && cs_ok && i_rom_busy) begin
				busy_flag_reg <= 1'b1;
			end else if (instr_done && cs_ok && is_stat_rd) begin
				busy_flag_reg <= 1'b0;
			end
			if (bad_pw || i_auth_order_err || (instr_done && cs_ok && bad_instr)) begin
				err_flag_reg <= 1'b1;
			end else if (instr_done && cs_ok && is_stat_rd) begin
				err_flag_reg <= 1'b0;
			end
		end
	end

	swl_tx #(
		.CNT_W(CNT_W)
	) u_tx (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_start(tx_start),
		.i_sym(tx_sym),
		.i_bit_cyc(bit_cyc),
		.o_busy(tx_busy),
		.o_pull_low(tx_pull)
	);

	assign o_line = 1'b0;
	assign o_line_oe_n = !tx_pull;
	assign o_asleep = st_reg == SWL_SLEEP;
	assign o_rom_busy_flag = busy_flag_reg;
	assign o_line_error_flag = err_flag_reg;
	assign o_instr = instr_reg;
	assign o_instr_valid = instr_valid_reg;
	assign o_wr_data = wr_data_reg;
	assign o_wr_valid = wr_valid_reg;
	assign o_rd_req = rd_req_reg;

	a_write_op: assert property (@(posedge i_clk) disable iff (!i_rstn)
		instr_done && cs_ok && !bad_instr && !i_rom_busy && op == swl_pkg::OP_WRITE
		|=> st_reg == SWL_WDATA)
		else $error("write opcode did not expect data bytes");
	a_sleep_op: assert property (@(posedge i_clk) disable iff (!i_rstn)
		sleep_cmd |=> o_asleep)
		else $error("sleep opcode did not put device to sleep");
	a_brk_wakes: assert property (@(posedge i_clk) disable iff (!i_rstn)
		brk_rx |=> st_reg == SWL_INSTR && bit_cnt_reg == 5'h00)
		else $error("break did not reset receiver");
	a_glitch_err: assert property (@(posedge i_clk) disable iff (!i_rstn)
		rise && is_glitch |=> o_line_error_flag)
		else $error("glitch did not flag bus error");
	a_busy_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
		instr_done && cs_ok && i_rom_busy |=> o_rom_busy_flag && !o_instr_valid)
		else $error("access during rom write not flagged");
	a_cs_ignore: assert property (@(posedge i_clk) disable iff (!i_rstn)
		instr_done && !cs_ok && !brk_rx |=> st_reg == SWL_IGNORE [*2])
		else $error("chip-select mismatch not ignored");
	a_cs_silent: assert property (@(posedge i_clk) disable iff (!i_rstn)
		st_reg == SWL_IGNORE |-> !rd_req_reg && !wr_valid_reg)
		else $error("unselected device answered");
	a_stat_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
		instr_done && cs_ok && is_stat_rd && !i_rom_busy && !bad_pw && !i_auth_order_err
		&& !bad_instr |=> !o_rom_busy_flag && !o_line_error_flag)
		else $error("status read did not clear flags");
	a_tx_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
		tx_start |-> i_line && !tx_busy)
		else $error("transmit started on a busy line");
	a_order_err: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_auth_order_err |=> o_line_error_flag)
		else $error("auth order error not flagged");
endmodule : swl_slave

// file: design/swl_tx.sv
/*
 * Symbol transmitter: drives one active-low pulse per symbol slot on the open-drain line; a data slot is one bit period.
 * Assumes the caller only starts a symbol while o_busy is low.
 */
`timescale 1ns/1ps
module swl_tx #(
	parameter int CNT_W = swl_pkg::CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_start,
	input wire swl_pkg::swl_sym_e i_sym,
	input wire logic [CNT_W-1:0] i_bit_cyc,
	output logic o_busy,
	output logic o_pull_low
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] low_reg;
	logic [CNT_W-1:0] span_reg;
	logic busy_reg;
	logic [CNT_W+11:0] frac_one;
	logic [CNT_W+11:0] frac_zero;
	logic [CNT_W+11:0] frac_brk;
	logic [CNT_W-1:0] low_sel;
	assign frac_one = ({12'h000, i_bit_cyc} * 36'(swl_pkg::TX_ONE_MIL)) / 36'd1000;
	assign frac_zero = ({12'h000, i_bit_cyc} * 36'(swl_pkg::TX_ZERO_MIL)) / 36'd1000;
	assign frac_brk = ({12'h000, i_bit_cyc} * 36'(swl_pkg::TX_BRK_MIL)) / 36'd1000;
	assign low_sel = (i_sym == swl_pkg::SWL_SYM_BRK) ? frac_brk[CNT_W-1:0] :
		(i_sym == swl_pkg::SWL_SYM_ZERO) ? frac_zero[CNT_W-1:0] :
		frac_one[CNT_W-1:0];
	assign o_busy = busy_reg;
	assign o_pull_low = busy_reg && (cnt_reg < low_reg);
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			busy_reg <= 1'b0;
			cnt_reg <= '0;
			low_reg <= '0;
			span_reg <= '0;
		end else if (!busy_reg && i_start) begin
			busy_reg <= 1'b1;
			cnt_reg <= '0;
			low_reg <= low_sel;
			// A break stretches its slot so the line is high for one period after it.
			span_reg <= (i_sym == swl_pkg::SWL_SYM_BRK) ? low_sel + i_bit_cyc : i_bit_cyc;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg + 1'b1;
			// Busy drops one cycle early so that the next start lands exactly one slot later.
			if (cnt_reg + 2'd2 >= span_reg) begin
				busy_reg <= 1'b0;
			end
		end
	end
endmodule : swl_tx

// file: tb/swl_host_model.sv
/*
 * Host model for the single-wire link: open-drain symbol sender and device pulse grader.
 * Assumes a pull-up on the line and the slave's 50 MHz clock; period is set by the bench.
 */
`timescale 1ns/1ps
module swl_host_model (
	input wire logic i_clk,
	input wire logic i_dev_oe_n,
	output logic o_pull_low
);
	int period = 200;
	int dw = 0;
	logic [1:0] rx_q[$];
	initial o_pull_low = 1'b0;
	function automatic bit near(input int w, input int mil);
		return (w * 1000 - mil * period) <= 2000 && (mil * period - w * 1000) <= 2000;
	endfunction : near
	// A device pulse off its nominal width by more than two cycles is logged as 3.
	always @(posedge i_clk) begin
		if (!i_dev_oe_n) begin
			dw++;
		end else if (dw > 0) begin
			rx_q.push_back(near(dw, 304) ? 2'h1 : near(dw, 696) ? 2'h0 : near(dw, 1391) ? 2'h2 : 2'h3);
			dw = 0;
		end
	end
	// Only a pull-low request is driven, so the pull-up alone makes the high level.
	task automatic sym(input int w);
		o_pull_low <= 1'b1;
		repeat (w) @(posedge i_clk);
		o_pull_low <= 1'b0;
		repeat ((w < period) ? period - w : period) @(posedge i_clk);
	endtask : sym
	task automatic send(input logic [15:0] v, input int n);
		for (int i = 0; i < n; i++) sym(v[i] ? period * 3 / 10 : period * 7 / 10);
	endtask : send
	task automatic brk();
		sym(2 * period);
	endtask : brk
endmodule : swl_host_model

// file: tb/test_swl_slave.sv
/*
 * Self-checking bench for the slave link: host model on the wire, register data on the user side.
 * Assumes the slave built with a 200-cycle base bit period to keep the run short.
 */
`timescale 1ns/1ps
module test_swl_slave;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [1:0] i_rate_sel = 2'h1;
	logic i_chip_addr = 1'b0;
	logic i_error_irq_enable = 1'b1;
	logic i_auto_sleep_en = 1'b0;
	logic i_rom_busy = 1'b0;
	logic i_auth_order_err = 1'b0;
	logic i_ready_req = 1'b0;
	logic [7:0] rd_byte = 8'h00;
	logic o_line, o_line_oe_n, pull, o_asleep, o_rom_busy_flag, o_line_error_flag;
	logic o_instr_valid, o_wr_valid, o_rd_req;
	logic [15:0] o_instr;
	logic [7:0] o_wr_data;
	logic [15:0] last_instr;
	logic [7:0] wr_q[$];
	int num_errors = 0;
	int tests_run = 0;
	int n_instr = 0;
	wire line = ~(pull | (~o_line_oe_n & ~o_line));
	swl_slave #(.BIT_CYC_BASE(200)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_line(line),
		.o_line(o_line), .o_line_oe_n(o_line_oe_n), .i_rate_sel(i_rate_sel),
		.i_chip_addr(i_chip_addr), .i_error_irq_enable(i_error_irq_enable),
		.i_auto_sleep_en(i_auto_sleep_en), .i_rom_busy(i_rom_busy),
		.i_auth_order_err(i_auth_order_err), .i_ready_req(i_ready_req), .o_asleep(o_asleep),
		.o_rom_busy_flag(o_rom_busy_flag), .o_line_error_flag(o_line_error_flag),
		.o_instr(o_instr), .o_instr_valid(o_instr_valid), .o_wr_data(o_wr_data),
		.o_wr_valid(o_wr_valid), .o_rd_req(o_rd_req), .i_rd_data(rd_byte));
	swl_host_model host (.i_clk(i_clk), .i_dev_oe_n(o_line_oe_n), .o_pull_low(pull));
	always #10 i_clk = ~i_clk;
	// Read data restarts at 8'h21 per instruction and steps by 8'h11 so a skipped byte shows.
	always @(posedge i_clk) begin
		if (o_instr_valid) begin
			n_instr++;
			last_instr = o_instr;
		end
		if (o_wr_valid) wr_q.push_back(o_wr_data);
		if (o_instr_valid) rd_byte <= 8'h21;
		else if (o_rd_req) rd_byte <= rd_byte + 8'h11;
	end
	function automatic logic [15:0] ins(input logic cs, input logic [1:0] op,
			input logic [1:0] bank, input logic [7:0] a, input logic [2:0] nb);
		return {nb, a, bank, op, cs};
	endfunction : ins
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
		return c;
	endfunction : crc_step
	task automatic wrap_up();
		$display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t data %h expected %h", $time, got, exp);
		end
	endtask : chk_data
	task automatic chk_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_flag
	// Returns one bit period after the n-th device pulse, leaving the host turn-around gap.
	task automatic wait_syms(input int n);
		for (int i = 0; host.rx_q.size() < n; i++) begin
			if (i > (n + 4) * 2 * host.period) begin
				num_errors++;
				$display("BAD t=%0t wait ran out", $time);
				wrap_up();
			end
			@(posedge i_clk);
		end
		repeat (host.period) @(posedge i_clk);
	endtask : wait_syms
	task automatic go(input logic [15:0] v);
		host.rx_q.delete();
		host.send(v, 16);
	endtask : go
	task automatic check_read(input int nb, input bit crc);
		logic [7:0] c;
		logic [7:0] e;
		logic [7:0] g;
		c = 8'h00;
		e = 8'h21;
		wait_syms(8 * (nb + crc));
		for (int k = 0; k < nb + crc; k++) begin
			if (k == nb) e = c;
			for (int i = 0; i < 8; i++) g[i] = (host.rx_q[8 * k + i] === {1'b0, e[i]}) ? e[i] : ~e[i];
			chk_data({8'h00, g}, {8'h00, e});
			c = crc_step(c, e);
			e = e + 8'h11;
		end
	endtask : check_read
	task automatic rd(input logic [7:0] a, input bit crc, input logic [2:0] nb, input int n);
		go(ins(1'b0, crc ? swl_pkg::OP_READ_CRC : swl_pkg::OP_READ, swl_pkg::BANK_CTRL, a, nb));
		check_read(n, crc);
	endtask : rd
	task automatic stat();
		go(ins(1'b0, swl_pkg::OP_READ, swl_pkg::BANK_CTRL, swl_pkg::ADDR_STATUS, 3'h1));
		wait_syms(8);
	endtask : stat
	task automatic chk_brk();
		wait_syms(1);
		chk_data({14'h0, host.rx_q[0]}, 16'h0002);
	endtask : chk_brk
	task automatic done(input string s);
		$display("test %s ended, errors so far %0d", s, num_errors);
	endtask : done
	initial begin
		int n0;
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk_flag(o_line_oe_n, 1'b1);
		chk_flag(o_line_error_flag | o_rom_busy_flag | o_asleep, 1'b0);
		done("reset");
		go(ins(1'b0, swl_pkg::OP_WRITE, swl_pkg::BANK_CTRL, 8'h10, 3'h2));
		host.send(16'h00C3, 8);
		host.send(16'h005A, 8);
		repeat (4) @(posedge i_clk);
		chk_data(last_instr, ins(1'b0, swl_pkg::OP_WRITE, swl_pkg::BANK_CTRL, 8'h10, 3'h2));
		chk_data(wr_q.size() == 2 ? {wr_q[0], wr_q[1]} : 16'hxxxx, 16'hC35A);
		chk_data(16'(host.rx_q.size()), 16'h0000);
		done("write");
		for (int r = 0; r < 4; r++) begin
			i_rate_sel <= r[1:0];
			host.period = 400 >> r;
			host.brk();
			rd(8'h10, 1'b0, 3'h1, 1);
		end
		done("rates");
		rd(8'h00, 1'b1, 3'h7, 16);
		done("crc");
		n0 = n_instr;
		go(ins(1'b1, swl_pkg::OP_READ, swl_pkg::BANK_CTRL, 8'h10, 3'h1));
		go(ins(1'b0, swl_pkg::OP_READ, swl_pkg::BANK_CTRL, 8'h10, 3'h1));
		repeat (2 * host.period) @(posedge i_clk);
		chk_data(16'(n_instr - n0), 16'h0000);
		chk_data(16'(host.rx_q.size()), 16'h0000);
		host.brk();
		rd(8'h10, 1'b0, 3'h1, 1);
		done("select");
		host.sym(3);
		chk_flag(o_line_error_flag, 1'b1);
		host.brk();
		go(ins(1'b0, swl_pkg::OP_READ, swl_pkg::BANK_CTRL, 8'h10, 3'h1));
		wait_syms(9);
		chk_flag(2'h2 inside {host.rx_q}, 1'b1);
		stat();
		chk_flag(o_line_error_flag, 1'b0);
		i_auth_order_err <= 1'b1;
		@(posedge i_clk);
		i_auth_order_err <= 1'b0;
		i_error_irq_enable <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk_flag(o_line_error_flag, 1'b1);
		rd(8'h10, 1'b0, 3'h1, 1);
		stat();
		i_error_irq_enable <= 1'b1;
		go(ins(1'b0, swl_pkg::OP_READ, swl_pkg::BANK_CTRL, 8'h10, 3'h3));
		chk_flag(o_line_error_flag, 1'b1);
		chk_data(16'(host.rx_q.size()), 16'h0000);
		host.brk();
		stat();
		done("errors");
		i_rom_busy <= 1'b1;
		go(ins(1'b0, swl_pkg::OP_WRITE, swl_pkg::BANK_CTRL, 8'h10, 3'h2));
		chk_brk();
		chk_flag(o_rom_busy_flag, 1'b1);
		i_rom_busy <= 1'b0;
		host.brk();
		stat();
		chk_flag(o_rom_busy_flag, 1'b0);
		host.rx_q.delete();
		i_ready_req <= 1'b1;
		@(posedge i_clk);
		i_ready_req <= 1'b0;
		chk_brk();
		done("busy_ready");
		host.send(ins(1'b0, swl_pkg::OP_SLEEP, 2'h0, 8'h00, 3'h0), 3);
		chk_flag(o_asleep, 1'b1);
		host.rx_q.delete();
		host.brk();
		chk_flag(o_asleep, 1'b0);
		chk_brk();
		done("sleep");
		i_auto_sleep_en <= 1'b1;
		repeat ((swl_pkg::IDLE_BITS - 8) * host.period) @(posedge i_clk);
		chk_flag(o_asleep, 1'b0);
		repeat (16 * host.period) @(posedge i_clk);
		chk_flag(o_asleep, 1'b1);
		done("auto_sleep");
		wrap_up();
	end
endmodule : test_swl_slave
